// ### rtl/pxm_pkg.sv
/*
 * Shared constants of the port crossbar and match block: register
 * addresses, reset values, writable masks and field positions.
 * Assumes an 8-bit special function register bus with 8-bit addresses.
 */
package pxm_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT0_DATA_LATCH = 8'h80;
    localparam logic [7:0] ADDR_PORT0_OUTPUT_MODE = 8'hA4;
    localparam logic [7:0] ADDR_CROSSBAR_ROUTING = 8'hE2;
    localparam logic [7:0] ADDR_CROSSBAR_GLOBAL = 8'hE3;
    localparam logic [7:0] ADDR_PORT0_INPUT_MODE = 8'hF1;
    localparam logic [7:0] ADDR_PORT_DRIVE_STRENGTH = 8'hF6;
    localparam logic [7:0] ADDR_PORT0_MATCH_VALUE = 8'hFD;
    localparam logic [7:0] ADDR_PORT0_COMPARE_MASK = 8'hFE;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PORT0_DATA_LATCH = 8'hFF;
    localparam logic [7:0] RST_PORT0_OUTPUT_MODE = 8'h00;
    localparam logic [7:0] RST_CROSSBAR_ROUTING = 8'h00;
    localparam logic [7:0] RST_CROSSBAR_GLOBAL = 8'h00;
    localparam logic [7:0] RST_PORT0_INPUT_MODE = 8'hFF;
    localparam logic [7:0] RST_PORT_DRIVE_STRENGTH = 8'h07;
    localparam logic [7:0] RST_PORT0_MATCH_VALUE = 8'hFF;
    localparam logic [7:0] RST_PORT0_COMPARE_MASK = 8'h00;

    // ------------------------------------------------------------------
    // Writable bits of the registers with reserved fields
    // ------------------------------------------------------------------
    localparam logic [7:0] WMASK_CROSSBAR_ROUTING = 8'h3F;
    localparam logic [7:0] WMASK_CROSSBAR_GLOBAL = 8'hC0;
    localparam logic [7:0] WMASK_PORT_DRIVE_STRENGTH = 8'h07;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_TIMER2_ROUTE = 5;
    localparam int BIT_TIMER1_ROUTE = 4;
    localparam int BIT_TIMER0_ROUTE = 3;
    localparam int BIT_EXT_COUNT_ROUTE = 2;
    localparam int BIT_CA_SEL_HI = 1;
    localparam int BIT_CA_SEL_LO = 0;
    localparam int BIT_WEAK_PULLUP_DISABLE = 7;
    localparam int BIT_CROSSBAR_ENABLE = 6;
    localparam int BIT_PORT2_DRIVE_HIGH = 2;
    localparam int BIT_PORT1_DRIVE_HIGH = 1;
    localparam int BIT_PORT0_DRIVE_HIGH = 0;

    // ------------------------------------------------------------------
    // Counter array pin select encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CA_SEL_NONE = 2'h0;
    localparam logic [1:0] CA_SEL_CH0 = 2'h1;
    localparam logic [1:0] CA_SEL_CH01 = 2'h2;
    localparam logic [1:0] CA_SEL_CH012 = 2'h3;

    localparam int PORT_WIDTH = 8;

endpackage

// ### rtl/pxm_match.sv
/*
 * Port mismatch comparator: one compare cell per pin, reduced to a flag.
 * Assumes pin levels are already synchronous to the system clock.
 */
module pxm_match (
    input wire logic [pxm_pkg::PORT_WIDTH-1:0] pin_level_i,
    input wire logic [pxm_pkg::PORT_WIDTH-1:0] compare_mask_i,
    input wire logic [pxm_pkg::PORT_WIDTH-1:0] match_value_i,
    output logic mismatch_o
);
    import pxm_pkg::*;

    logic [PORT_WIDTH-1:0] bit_differs;

    // ------------------------------------------------------------------
    // Per-pin compare
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PORT_WIDTH; gi = gi + 1) begin : g_cell
            // A cleared mask bit removes the pin from the compare.
            // The match bit is the expected level of the pin.
            assign bit_differs[gi] = compare_mask_i[gi] & (pin_level_i[gi] ^ match_value_i[gi]);
        end
    endgenerate

    // Purely combinational, evaluated every cycle.
    assign mismatch_o = |bit_differs;

endmodule

// ### rtl/pxm_port.sv
/*
 * Port I/O configuration block: crossbar routing enables, weak pull-up
 * control, per-port drive strength, port 0 latch, pin modes and the
 * port match event.
 * Assumes a one-cycle special function register bus from the core, pad
 * levels synchronous to clk_i, and pads that resolve the drive enables.
 */
module pxm_port (
    input wire logic clk_i,
    input wire logic nrst_i,
    // Special function register bus.
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    input wire logic sfr_rmw_i,
    output logic [7:0] sfr_rdata_o,
    // Port 0 pads.
    input wire logic [pxm_pkg::PORT_WIDTH-1:0] port0_pin_i,
    output logic [pxm_pkg::PORT_WIDTH-1:0] port0_pin_o,
    output logic [pxm_pkg::PORT_WIDTH-1:0] port0_pin_oe_o,
    output logic [pxm_pkg::PORT_WIDTH-1:0] port0_pullup_en_o,
    output logic [pxm_pkg::PORT_WIDTH-1:0] port0_receiver_en_o,
    // Drive strength, one bit per port.
    output logic port2_drive_high_o,
    output logic port1_drive_high_o,
    output logic port0_drive_high_o,
    // Global weak pull-up gate for ports handled elsewhere.
    output logic weak_pullup_active_o,
    // Crossbar routing requests towards the priority decoder.
    output logic crossbar_enable_o,
    output logic timer2_input_route_enable_o,
    output logic timer1_input_route_enable_o,
    output logic timer0_input_route_enable_o,
    output logic external_count_input_route_enable_o,
    output logic counter_array_channel_0_pin_o,
    output logic counter_array_channel_1_pin_o,
    output logic counter_array_channel_2_pin_o,
    // Port mismatch event.
    input wire logic other_ports_mismatch_i,
    output logic port_mismatch_o
);
    import pxm_pkg::*;

    // Functional notes
    // - Routing bits 5, 4, 3 route timer 2, 1, 0 inputs to pins.
    // - Routing bit 2 routes the counter array external count input.
    // - Routing bits 1:0 route none, channel 0, channels 0-1, channels 0-2.
    // - Global bit 7 clear keeps weak pull-ups on except analog pins; the code also drops them on pins driven low.
    // - Global bit 6 enables the crossbar; clear routes nothing to pins.
    // - Drive bits 2, 1, 0 pick high or low drive for ports 2, 1, 0.
    // - Mask bit 1 includes its port 0 pin in the match compare.
    // - Match bit gives the expected pin level, 0 low, 1 high.
    // - Writing port 0 data updates the latch driving digital pins.
    // - Reading port 0 data returns the actual pin levels.
    // - Input mode bit 0 is analog: no pull-up, driver or receiver.
    // - Masked pin levels differing from masked match raise a mismatch event.
    // - Output mode bit 0 is open-drain, 1 push-pull, digital pins only.
    // - Read-modify-write reads of port 0 data return the latch, not pins.

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] port0_data_latch;
    logic [7:0] port0_output_mode;
    logic [7:0] crossbar_timer_counter_routing;
    logic [7:0] crossbar_global_control;
    logic [7:0] port0_input_mode;
    logic [7:0] port_drive_strength;
    logic [7:0] port0_match_value;
    logic [7:0] port0_compare_mask;
    logic [7:0] rdata;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire sel_data = sfr_addr_i == ADDR_PORT0_DATA_LATCH;
    wire sel_out_mode = sfr_addr_i == ADDR_PORT0_OUTPUT_MODE;
    wire sel_routing = sfr_addr_i == ADDR_CROSSBAR_ROUTING;
    wire sel_global = sfr_addr_i == ADDR_CROSSBAR_GLOBAL;
    wire sel_in_mode = sfr_addr_i == ADDR_PORT0_INPUT_MODE;
    wire sel_drive = sfr_addr_i == ADDR_PORT_DRIVE_STRENGTH;
    wire sel_match = sfr_addr_i == ADDR_PORT0_MATCH_VALUE;
    wire sel_mask = sfr_addr_i == ADDR_PORT0_COMPARE_MASK;

    // Reserved fields are forced to their reset value, so a careless write
    // cannot disturb them even though software is expected to preserve them.
    wire [7:0] next_routing = (sfr_wdata_i & WMASK_CROSSBAR_ROUTING)
                            | (RST_CROSSBAR_ROUTING & ~WMASK_CROSSBAR_ROUTING);
    wire [7:0] next_global = (sfr_wdata_i & WMASK_CROSSBAR_GLOBAL)
                           | (RST_CROSSBAR_GLOBAL & ~WMASK_CROSSBAR_GLOBAL);
    wire [7:0] next_drive = (sfr_wdata_i & WMASK_PORT_DRIVE_STRENGTH)
                          | (RST_PORT_DRIVE_STRENGTH & ~WMASK_PORT_DRIVE_STRENGTH);

    // ------------------------------------------------------------------
    // Pin read-back
    // ------------------------------------------------------------------
    // An analog pin has its receiver off, so its read-back bit is zero.
    wire [7:0] pin_level = port0_pin_i & port0_input_mode;

    // Plain reads see the pads; read-modify-write reads see the latch.
    wire [7:0] data_read = sfr_rmw_i ? port0_data_latch : pin_level;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    wire [7:0] next_rdata = sel_data ? data_read :
                            sel_out_mode ? port0_output_mode :
                            sel_routing ? crossbar_timer_counter_routing :
                            sel_global ? crossbar_global_control :
                            sel_in_mode ? port0_input_mode :
                            sel_drive ? port_drive_strength :
                            sel_match ? port0_match_value :
                            sel_mask ? port0_compare_mask :
                            8'h00;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port0_data_latch <= RST_PORT0_DATA_LATCH;
            port0_output_mode <= RST_PORT0_OUTPUT_MODE;
            port0_input_mode <= RST_PORT0_INPUT_MODE;
            port0_match_value <= RST_PORT0_MATCH_VALUE;
            port0_compare_mask <= RST_PORT0_COMPARE_MASK;
        end else if (sfr_wr_i) begin
            if (sel_data) begin
                port0_data_latch <= sfr_wdata_i;
            end
            if (sel_out_mode) begin
                port0_output_mode <= sfr_wdata_i;
            end
            if (sel_in_mode) begin
                port0_input_mode <= sfr_wdata_i;
            end
            if (sel_match) begin
                port0_match_value <= sfr_wdata_i;
            end
            if (sel_mask) begin
                port0_compare_mask <= sfr_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            crossbar_timer_counter_routing <= RST_CROSSBAR_ROUTING;
            crossbar_global_control <= RST_CROSSBAR_GLOBAL;
            port_drive_strength <= RST_PORT_DRIVE_STRENGTH;
        end else if (sfr_wr_i) begin
            if (sel_routing) begin
                crossbar_timer_counter_routing <= next_routing;
            end
            if (sel_global) begin
                crossbar_global_control <= next_global;
            end
            if (sel_drive) begin
                port_drive_strength <= next_drive;
            end
        end
    end

    // Read data is captured on the strobe and held until the next read.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata <= 8'h00;
        end else if (sfr_rd_i) begin
            rdata <= next_rdata;
        end
    end

    assign sfr_rdata_o = rdata;

    // ------------------------------------------------------------------
    // Crossbar routing
    // ------------------------------------------------------------------
    wire xbar_on = crossbar_global_control[BIT_CROSSBAR_ENABLE];
    wire [1:0] ca_sel = crossbar_timer_counter_routing[BIT_CA_SEL_HI:BIT_CA_SEL_LO];

    assign crossbar_enable_o = xbar_on;
    assign timer2_input_route_enable_o =
        xbar_on & crossbar_timer_counter_routing[BIT_TIMER2_ROUTE];
    assign timer1_input_route_enable_o =
        xbar_on & crossbar_timer_counter_routing[BIT_TIMER1_ROUTE];
    assign timer0_input_route_enable_o =
        xbar_on & crossbar_timer_counter_routing[BIT_TIMER0_ROUTE];
    assign external_count_input_route_enable_o =
        xbar_on & crossbar_timer_counter_routing[BIT_EXT_COUNT_ROUTE];

    // The channel count grows with the code, so each channel is a compare.
    assign counter_array_channel_0_pin_o = xbar_on & (ca_sel >= CA_SEL_CH0);
    assign counter_array_channel_1_pin_o = xbar_on & (ca_sel >= CA_SEL_CH01);
    assign counter_array_channel_2_pin_o = xbar_on & (ca_sel == CA_SEL_CH012);

    // ------------------------------------------------------------------
    // Drive strength
    // ------------------------------------------------------------------
    assign port2_drive_high_o = port_drive_strength[BIT_PORT2_DRIVE_HIGH];
    assign port1_drive_high_o = port_drive_strength[BIT_PORT1_DRIVE_HIGH];
    assign port0_drive_high_o = port_drive_strength[BIT_PORT0_DRIVE_HIGH];

    // ------------------------------------------------------------------
    // Port 0 pad control
    // ------------------------------------------------------------------
    wire pullups_on = ~crossbar_global_control[BIT_WEAK_PULLUP_DISABLE];
    wire [7:0] digital = port0_input_mode;
    wire [7:0] drive_low = digital & ~port0_data_latch;
    wire [7:0] drive_high = digital & port0_data_latch & port0_output_mode;

    assign weak_pullup_active_o = pullups_on;

    // Open-drain pins only pull low; push-pull pins drive both rails.
    assign port0_pin_o = drive_high;
    assign port0_pin_oe_o = drive_low | drive_high;

    // The pull-up is dropped while the pad is driven low to save current,
    // and never applied to an analog pin.
    assign port0_pullup_en_o = {PORT_WIDTH{pullups_on}} & digital & ~drive_low;
    assign port0_receiver_en_o = digital;

    // ------------------------------------------------------------------
    // Port match
    // ------------------------------------------------------------------
    logic port0_mismatch;

    pxm_match u_match (
        .pin_level_i(pin_level),
        .compare_mask_i(port0_compare_mask),
        .match_value_i(port0_match_value),
        .mismatch_o(port0_mismatch)
    );

    // Combinational so that a mismatch can wake the core without a clock
    // edge of latency.
    assign port_mismatch_o = port0_mismatch | other_ports_mismatch_i;

endmodule

// ### tb/pxm_port_chk.sv
/*
 * Concurrent checks on the ports of the port crossbar and match block.
 * Assumes it is bound onto pxm_port and sees nothing but its ports.
 */
module pxm_port_chk
    import pxm_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    input wire logic sfr_rmw_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [PORT_WIDTH-1:0] port0_pin_i,
    input wire logic [PORT_WIDTH-1:0] port0_pin_oe_o,
    input wire logic [PORT_WIDTH-1:0] port0_pullup_en_o,
    input wire logic [PORT_WIDTH-1:0] port0_receiver_en_o,
    input wire logic port2_drive_high_o,
    input wire logic port1_drive_high_o,
    input wire logic port0_drive_high_o,
    input wire logic weak_pullup_active_o,
    input wire logic crossbar_enable_o,
    input wire logic timer2_input_route_enable_o,
    input wire logic timer1_input_route_enable_o,
    input wire logic timer0_input_route_enable_o,
    input wire logic external_count_input_route_enable_o,
    input wire logic counter_array_channel_0_pin_o,
    input wire logic counter_array_channel_1_pin_o,
    input wire logic counter_array_channel_2_pin_o,
    input wire logic other_ports_mismatch_i,
    input wire logic port_mismatch_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_port_read: assert property (sfr_rd_i && !sfr_rmw_i && sfr_addr_i == 8'h80 |=>
        sfr_rdata_o == ($past(port0_pin_i) & $past(port0_receiver_en_o)))
        else $error("port read does not return the pin levels");
    a_rdata_hold: assert property (!$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
        else $error("read data moved without a read");
    a_glob_write: assert property (sfr_wr_i && sfr_addr_i == 8'hE3 |=>
        crossbar_enable_o == $past(sfr_wdata_i[6]) && weak_pullup_active_o != $past(sfr_wdata_i[7]))
        else $error("global control write not applied");
    a_drive_write: assert property (sfr_wr_i && sfr_addr_i == 8'hF6 |=>
        {port2_drive_high_o, port1_drive_high_o, port0_drive_high_o} == $past(sfr_wdata_i[2:0]))
        else $error("drive strength write not applied");
    a_glob_resv: assert property (sfr_rd_i && sfr_addr_i == 8'hE3 |=> sfr_rdata_o[5:0] == 6'h00)
        else $error("reserved global bits read nonzero");
    a_drive_resv: assert property (sfr_rd_i && sfr_addr_i == 8'hF6 |=> sfr_rdata_o[7:3] == 5'h00)
        else $error("reserved drive bits read nonzero");
    a_route_gate: assert property (!crossbar_enable_o |-> !(timer2_input_route_enable_o ||
        timer1_input_route_enable_o || timer0_input_route_enable_o ||
        external_count_input_route_enable_o || counter_array_channel_0_pin_o))
        else $error("route active with crossbar off");
    a_channel_chain: assert property ((!counter_array_channel_2_pin_o ||
        counter_array_channel_1_pin_o) && (!counter_array_channel_1_pin_o || counter_array_channel_0_pin_o))
        else $error("counter channels routed out of order");
    a_analog_quiet: assert property ((~port0_receiver_en_o &
        (port0_pullup_en_o | port0_pin_oe_o)) == 8'h00)
        else $error("analog pin has pull-up or driver on");
    a_pullup_gate: assert property (!weak_pullup_active_o |-> port0_pullup_en_o == 8'h00)
        else $error("pull-up on while globally disabled");
    a_other_or: assert property (other_ports_mismatch_i |-> port_mismatch_o)
        else $error("other port mismatch not passed on");

    c_full_route: cover property (crossbar_enable_o && counter_array_channel_2_pin_o);
    c_own_mismatch: cover property (port_mismatch_o && !other_ports_mismatch_i);
    c_rmw_read: cover property (sfr_rd_i && sfr_rmw_i);
endmodule

// ### tb/pxm_pad_model.sv
/*
 * Pads and outside circuitry of port 0.
 * Assumes the bench drives ext_en_i and ext_val_i in place of outside parts.
 */
module pxm_pad_model (
    input wire logic clk_i,
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    input wire logic [7:0] pullup_en_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] level_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] float_q = 8'h00;
    // A pad nobody drives or pulls must not look like a steady level.
    always @(posedge clk_i) float_q <= ~float_q;
    // An open-drain high shows only through the pull-up or outside drive.
    assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_en_i & ext_val_i)
        | (~pin_oe_i & ~ext_en_i & (pullup_en_i | float_q));
endmodule

// ### tb/pxm_port_tb.sv
/*
 * Self-checking bench of the port crossbar and match block.
 * Assumes the pad model stands for everything outside port 0.
 */
module pxm_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pxm_pkg::*;
    logic clk_i = 0, nrst_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, sfr_rmw_i = 0;
    logic other_ports_mismatch_i = 0, port2_drive_high_o, port1_drive_high_o;
    logic port0_drive_high_o, weak_pullup_active_o, crossbar_enable_o, port_mismatch_o;
    logic timer2_input_route_enable_o, timer1_input_route_enable_o, timer0_input_route_enable_o;
    logic external_count_input_route_enable_o, counter_array_channel_0_pin_o;
    logic counter_array_channel_1_pin_o, counter_array_channel_2_pin_o;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, port0_pin_i, port0_pin_o;
    logic [7:0] port0_pin_oe_o, port0_pullup_en_o, port0_receiver_en_o;
    logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
    int err_count = 0, tests_run = 0, cycles = 0;

    pxm_port dut (.clk_i, .nrst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rmw_i,
        .sfr_rdata_o, .port0_pin_i, .port0_pin_o, .port0_pin_oe_o, .port0_pullup_en_o,
        .port0_receiver_en_o, .port2_drive_high_o, .port1_drive_high_o, .port0_drive_high_o,
        .weak_pullup_active_o, .crossbar_enable_o, .timer2_input_route_enable_o,
        .timer1_input_route_enable_o, .timer0_input_route_enable_o,
        .external_count_input_route_enable_o, .counter_array_channel_0_pin_o,
        .counter_array_channel_1_pin_o, .counter_array_channel_2_pin_o,
        .other_ports_mismatch_i, .port_mismatch_o);
    pxm_pad_model pads (.clk_i(clk_i), .pin_o_i(port0_pin_o), .pin_oe_i(port0_pin_oe_o),
        .pullup_en_i(port0_pullup_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .level_o(port0_pin_i));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Each access takes two cycles so that a strobe is never lowered and raised at once.
    task automatic access(input logic [7:0] a, input logic w, input logic m, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = w;
        sfr_rd_i = !w;
        sfr_rmw_i = m;
        @(posedge clk_i);
        #2;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        sfr_rmw_i = 1'b0;
        @(posedge clk_i);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(a, 1'b1, 1'b0, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic m, input logic [7:0] e, input string nm);
        access(a, 1'b0, m, 8'h00);
        chk(nm, sfr_rdata_o, e);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] a[8] = '{8'hA4, 8'hE2, 8'hE3, 8'hF1, 8'hF6, 8'hFD, 8'hFE, 8'h00};
        logic [7:0] e[8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h07, 8'hFF, 8'h00, 8'h00};
        foreach (a[i]) rdc(a[i], 1'b0, e[i], "reset value");
        rdc(8'h80, 1'b0, 8'hFF, "pulled-up pins");
        chk("pin enables", port0_pin_oe_o, 8'h00);
    endtask
    task automatic t_route();
        wr(8'hE2, 8'hFF);
        rdc(8'hE2, 1'b0, 8'h3F, "routing readback");
        wr(8'hF6, 8'hFF);
        rdc(8'hF6, 1'b0, 8'h07, "drive readback");
        wr(8'hE3, 8'hFF);
        rdc(8'hE3, 1'b0, 8'hC0, "global readback");
        chk("pull-ups off", port0_pullup_en_o, 8'h00);
        wr(8'hE3, 8'h40);
        chk("pull-ups on", {port0_pullup_en_o[7:1], weak_pullup_active_o}, 8'hFF);
        for (int s = 0; s < 4; s++) begin
            wr(8'hE2, (8'h04 << s) | 8'(s));
            chk("routes", {1'b0, timer2_input_route_enable_o, timer1_input_route_enable_o,
                timer0_input_route_enable_o, external_count_input_route_enable_o,
                counter_array_channel_2_pin_o, counter_array_channel_1_pin_o,
                counter_array_channel_0_pin_o}, {1'b0, 4'(1 << s), 3'(7 >> (3 - s))});
        end
        wr(8'hE3, 8'h00);
        chk("gated routes", {timer2_input_route_enable_o, timer1_input_route_enable_o,
            timer0_input_route_enable_o, external_count_input_route_enable_o,
            counter_array_channel_2_pin_o, counter_array_channel_1_pin_o,
            counter_array_channel_0_pin_o, crossbar_enable_o}, 8'h00);
        for (int v = 0; v < 8; v++) begin
            wr(8'hF6, 8'(v));
            chk("drive", {5'h00, port2_drive_high_o, port1_drive_high_o, port0_drive_high_o},
                8'(v));
        end
    endtask
    task automatic t_match();
        logic [7:0] pat[5] = '{8'hA5, 8'hB5, 8'h25, 8'hAA, 8'hF0};
        logic [7:0] exp[5] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
        wr(8'hFE, 8'hF0);
        wr(8'hFD, 8'hA0);
        ext_en = 8'hFF;
        foreach (pat[i]) begin
            ext_val = pat[i];
            @(negedge clk_i);
            chk("own mismatch", {7'h00, port_mismatch_o}, exp[i]);
            @(posedge clk_i);
            #2;
        end
        ext_val = 8'hA5;
        other_ports_mismatch_i = 1'b1;
        @(negedge clk_i);
        chk("other mismatch", {7'h00, port_mismatch_o}, 8'h01);
        @(posedge clk_i);
        #2;
        other_ports_mismatch_i = 1'b0;
        wr(8'hF1, 8'h7F);
        chk("analog pin", {port0_receiver_en_o[7], port0_pullup_en_o[7], 5'h00,
            port_mismatch_o}, 8'h01);
        wr(8'hF1, 8'hFF);
        ext_en = 8'h00;
    endtask
    task automatic t_latch();
        wr(8'hA4, 8'h0F);
        wr(8'h80, 8'h5A);
        chk("pin enables", port0_pin_oe_o, 8'hAF);
        chk("pin values", port0_pin_o & port0_pin_oe_o, 8'h0A);
        ext_en = 8'h40;
        ext_val = 8'h00;
        rdc(8'h80, 1'b0, 8'h1A, "pin read");
        rdc(8'h80, 1'b1, 8'h5A, "latch read");
        ext_en = 8'h00;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        #2;
        nrst_i = 1'b1;
        t_reset();
        t_route();
        t_match();
        t_latch();
        close_out();
    end

    // The whole run needs about a hundred cycles; this only catches a hang.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end
endmodule

bind pxm_port pxm_port_chk chk (.clk_i, .nrst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rd_i, .sfr_rmw_i, .sfr_rdata_o, .port0_pin_i, .port0_pin_oe_o, .port0_pullup_en_o,
    .port0_receiver_en_o, .port2_drive_high_o, .port1_drive_high_o, .port0_drive_high_o,
    .weak_pullup_active_o, .crossbar_enable_o, .timer2_input_route_enable_o,
    .timer1_input_route_enable_o, .timer0_input_route_enable_o,
    .external_count_input_route_enable_o, .counter_array_channel_0_pin_o,
    .counter_array_channel_1_pin_o, .counter_array_channel_2_pin_o,
    .other_ports_mismatch_i, .port_mismatch_o);
